// file: design/lic_control2.sv
// Control-two register bank of the line interface with Wishbone slave and interrupt
//
// Notes on behaviour
// - Writing one to the manual calibrate bit starts calibration; zero requests nothing.
// - Automatic calibration runs while auto calibrate disable is zero, suppressed when one.
// - Current limit enable acts only in current-limiting mode, limiting before 60 mA.
// - Off-hook, protect enabled, loop reading all ones: drop termination, reduce hook current.
// - Off-hook, billing protect enabled, billing flag rises: termination high-Z, tracking stops.
// - Receive overload flag sets on excessive input, stays until software writes zero.
// - Billing tone flag sets on detected tone, stays until software writes zero.
// - Current-limiting mode is termination mode select value binary 11.
`timescale 1ns/1ps
`default_nettype none
module lic_control2 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lic_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [lic_pkg::DAT_W-1:0] wb_dat_i,
    output logic [lic_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Line state from same-clock logic
    input wire logic off_hook,
    input wire logic [4:0] loop_current_reading,
    input wire logic [1:0] termination_mode_select,
    // Asynchronous analog status pins
    input wire logic rx_overload_pin,
    input wire logic billing_tone_pin,
    input wire logic cal_done_pin,
    // Line-side controls
    output logic cal_start,
    output logic auto_calibrate_enable,
    output logic current_limit_active,
    output logic termination_disable,
    output logic hook_current_reduce,
    output logic termination_high_z,
    output logic termination_tracking,
    // Interrupt
    output logic irq
);
    import lic_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic calibrating;
        logic auto_calibrate_disable;
        logic current_limit_enable;
        logic overload_protect_enable;
        logic billing_tone_protect_enable;
        logic receive_overload_flag;
        logic billing_tone_flag;
        logic overload_protect_detected;
        logic billing_protect_active;
        logic billing_tone_prev;
        logic off_hook_prev;
        logic cal_done_prev;
        logic cal_start;
        logic [EV_W-1:0] int_stat;
        logic [EV_W-1:0] int_mask;
        logic ack;
        logic [DAT_W-1:0] dat;
    } lic_state_t;

    lic_state_t s;
    lic_state_t next_s;

    logic [SYNC_W-1:0] pin_s;
    logic req;
    logic [5:0] idx;
    logic wr_lane0;
    logic wr_ctrl;
    logic off_rise;
    logic auto_cal;
    logic man_cal;
    logic bill_rise;
    logic cal_done_rise;
    logic ovl_hit;
    logic [EV_W-1:0] ev;
    logic [7:0] ctrl_rd;
    logic [EV_W-1:0] line_rd;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    lic_pin_sync lic_pin_sync_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_raw({cal_done_pin, billing_tone_pin, rx_overload_pin}),
        .pin_sync(pin_s)
    );

    // Request decode; ack gating keeps one answer per request
    assign req = wb_cyc_i & wb_stb_i & ~s.ack;
    assign idx = wb_adr_i[7:2];
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
    assign wr_ctrl = wr_lane0 && (idx == IDX_CTRL2);

    // Line events
    assign off_rise = off_hook & ~s.off_hook_prev;
    assign auto_cal = off_rise & ~s.auto_calibrate_disable;
    assign man_cal = wr_ctrl & wb_dat_i[BIT_MANUAL_CAL];
    assign bill_rise = s.billing_tone_flag & ~s.billing_tone_prev;
    assign cal_done_rise = pin_s[SY_CAL_DONE] & ~s.cal_done_prev;
    assign ovl_hit = off_hook & s.overload_protect_enable
        & (loop_current_reading == LOOP_ALL_ONES);

    // Sticky interrupt events, each a single-cycle cause
    assign ev[EV_CAL_DONE] = cal_done_rise & s.calibrating;
    assign ev[EV_OVERLOAD] = ovl_hit & ~s.overload_protect_detected;
    assign ev[EV_RX_OVL] = pin_s[SY_RX_OVL] & ~s.receive_overload_flag;
    assign ev[EV_BILL] = pin_s[SY_BILL] & ~s.billing_tone_flag;

    // Read views; top bit of control-two reads zero
    assign ctrl_rd = {1'b0, s.calibrating, s.auto_calibrate_disable, s.current_limit_enable,
        s.overload_protect_enable, s.billing_tone_protect_enable,
        s.receive_overload_flag, s.billing_tone_flag};
    assign line_rd = {s.billing_protect_active, s.overload_protect_detected,
        s.calibrating, s.off_hook_prev};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.ack = req;
        next_s.off_hook_prev = off_hook;
        next_s.cal_done_prev = pin_s[SY_CAL_DONE];
        next_s.billing_tone_prev = s.billing_tone_flag;

        // Calibration start pulse; a start beats a done in the same cycle
        next_s.cal_start = man_cal | auto_cal;
        if (man_cal || auto_cal)
        begin
            next_s.calibrating = 1'b1;
        end
        else if (cal_done_rise)
        begin
            next_s.calibrating = 1'b0;
        end

        // Control field writes
        if (wr_ctrl)
        begin
            next_s.auto_calibrate_disable = wb_dat_i[BIT_AUTO_CAL_DIS];
            next_s.current_limit_enable = wb_dat_i[BIT_CUR_LIMIT];
            next_s.overload_protect_enable = wb_dat_i[BIT_OVL_PROT];
            next_s.billing_tone_protect_enable = wb_dat_i[BIT_BILL_PROT];
        end

        // Sticky flags: write zero clears, write one keeps, hardware set wins
        if (wr_ctrl && !wb_dat_i[BIT_RX_OVL])
        begin
            next_s.receive_overload_flag = 1'b0;
        end
        if (pin_s[SY_RX_OVL])
        begin
            next_s.receive_overload_flag = 1'b1;
        end
        if (wr_ctrl && !wb_dat_i[BIT_BILL_FLAG])
        begin
            next_s.billing_tone_flag = 1'b0;
        end
        if (pin_s[SY_BILL])
        begin
            next_s.billing_tone_flag = 1'b1;
        end

        // Overload latch holds until software drops the enable
        if (!s.overload_protect_enable)
        begin
            next_s.overload_protect_detected = 1'b0;
        end
        else if (ovl_hit)
        begin
            next_s.overload_protect_detected = 1'b1;
        end

        // Billing protection ends when disabled or back on-hook
        if (!s.billing_tone_protect_enable || !off_hook)
        begin
            next_s.billing_protect_active = 1'b0;
        end
        else if (bill_rise)
        begin
            next_s.billing_protect_active = 1'b1;
        end

        // Interrupt status: write one clears, new event wins
        if (wr_lane0 && (idx == IDX_INT_STAT))
        begin
            next_s.int_stat = s.int_stat & ~wb_dat_i[EV_W-1:0];
        end
        next_s.int_stat = next_s.int_stat | ev;
        if (wr_lane0 && (idx == IDX_INT_MASK))
        begin
            next_s.int_mask = wb_dat_i[EV_W-1:0];
        end

        // Read data, unmapped addresses answer with zero
        if (req && !wb_we_i)
        begin
            if (idx == IDX_CTRL2)
            begin
                next_s.dat = {24'h000000, ctrl_rd};
            end
            else if (idx == IDX_INT_STAT)
            begin
                next_s.dat = {28'h0000000, s.int_stat};
            end
            else if (idx == IDX_INT_MASK)
            begin
                next_s.dat = {28'h0000000, s.int_mask};
            end
            else if (idx == IDX_LINE_STAT)
            begin
                next_s.dat = {28'h0000000, line_rd};
            end
            else
            begin
                next_s.dat = 32'h00000000;
            end
        end

        // Synchronous reset
        if (!rst_n)
        begin
            next_s = '0;
            {next_s.auto_calibrate_disable, next_s.current_limit_enable,
                next_s.overload_protect_enable, next_s.billing_tone_protect_enable,
                next_s.receive_overload_flag, next_s.billing_tone_flag} = CTRL2_RST[5:0];
            next_s.int_stat = INT_STAT_RST;
            next_s.int_mask = INT_MASK_RST;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s <= next_s;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.dat;
    assign cal_start = s.cal_start;
    assign auto_calibrate_enable = ~s.auto_calibrate_disable;
    // Limit only counts in the current-limiting termination mode
    assign current_limit_active = s.current_limit_enable
        & (termination_mode_select == MODE_CURRENT_LIMITING);
    assign termination_disable = s.overload_protect_detected;
    assign hook_current_reduce = s.overload_protect_detected;
    assign termination_high_z = s.billing_protect_active;
    assign termination_tracking = ~s.billing_protect_active;
    assign irq = |(s.int_stat & s.int_mask);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_manual_cal_start: assert property (
        wr_ctrl && wb_dat_i[BIT_MANUAL_CAL] |=> cal_start ##1 !cal_start)
        else $error("manual calibrate write gave no single start pulse");

    chk_cal_cause: assert property (
        cal_start |-> $past(man_cal) || $past(auto_cal))
        else $error("calibration started without a cause");

    chk_auto_cal_gate: assert property (
        off_hook && !s.off_hook_prev && s.auto_calibrate_disable && !wr_ctrl
        |=> !cal_start)
        else $error("auto calibration ran while disabled");

    chk_limit_mode: assert property (
        termination_mode_select != MODE_CURRENT_LIMITING |-> !current_limit_active)
        else $error("current limit active outside current-limiting mode");

    chk_limit_select: assert property (
        wr_ctrl && wb_dat_i[BIT_CUR_LIMIT] ##1 termination_mode_select == 2'h3
        |-> current_limit_active)
        else $error("current limit missing in mode 11");

    chk_overload_trip: assert property (
        ovl_hit |=> termination_disable && hook_current_reduce && line_rd[LS_OVL_DET])
        else $error("overload protection did not trip");

    chk_billing_protect: assert property (
        off_hook && s.billing_tone_protect_enable && bill_rise
        |=> termination_high_z && !termination_tracking)
        else $error("billing protection did not engage");

    chk_rx_ovl_sticky: assert property (
        s.receive_overload_flag && !(wr_ctrl && !wb_dat_i[BIT_RX_OVL])
        |=> s.receive_overload_flag)
        else $error("receive overload flag lost");

    chk_bill_flag_sticky: assert property (
        $rose(pin_s[SY_BILL]) |=> s.billing_tone_flag [*2])
        else $error("billing tone flag not set and held");

    chk_flag_no_sw_set: assert property (
        wr_ctrl && !s.billing_tone_flag && !pin_s[SY_BILL] |=> !s.billing_tone_flag)
        else $error("software set the billing tone flag");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// file: include/lic_pkg.sv
// Shared constants for the line interface control-two register block
package lic_pkg;
    // ----------------------------------------------------------------
    // Bus geometry and register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam logic [5:0] IDX_CTRL2 = 6'h11;
    localparam logic [5:0] IDX_INT_STAT = 6'h20;
    localparam logic [5:0] IDX_INT_MASK = 6'h21;
    localparam logic [5:0] IDX_LINE_STAT = 6'h22;

    // ----------------------------------------------------------------
    // Control-two field positions
    // ----------------------------------------------------------------
    localparam int BIT_MANUAL_CAL = 6;
    localparam int BIT_AUTO_CAL_DIS = 5;
    localparam int BIT_CUR_LIMIT = 4;
    localparam int BIT_OVL_PROT = 3;
    localparam int BIT_BILL_PROT = 2;
    localparam int BIT_RX_OVL = 1;
    localparam int BIT_BILL_FLAG = 0;

    // ----------------------------------------------------------------
    // Interrupt event and line status positions
    // ----------------------------------------------------------------
    localparam int EV_W = 4;
    localparam int EV_CAL_DONE = 0;
    localparam int EV_OVERLOAD = 1;
    localparam int EV_RX_OVL = 2;
    localparam int EV_BILL = 3;
    localparam int LS_OFF_HOOK = 0;
    localparam int LS_CALIBRATING = 1;
    localparam int LS_OVL_DET = 2;
    localparam int LS_BILL_ACTIVE = 3;

    // ----------------------------------------------------------------
    // Values after reset and line encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
    localparam logic [EV_W-1:0] INT_STAT_RST = 4'h0;
    localparam logic [1:0] MODE_CURRENT_LIMITING = 2'h3;
    localparam logic [4:0] LOOP_ALL_ONES = 5'h1f;

    // ----------------------------------------------------------------
    // Pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int SYNC_W = 3;
    localparam int SY_RX_OVL = 0;
    localparam int SY_BILL = 1;
    localparam int SY_CAL_DONE = 2;
endpackage

// file: design/lic_pin_sync.sv
// Two-stage synchroniser for the asynchronous line-side status pins
`timescale 1ns/1ps
`default_nettype none
module lic_pin_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Raw pins and their synchronised copies
    input wire logic [lic_pkg::SYNC_W-1:0] pin_raw,
    output logic [lic_pkg::SYNC_W-1:0] pin_sync
);
    import lic_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] first;
        logic [SYNC_W-1:0] second;
    } lic_sync_t;

    lic_sync_t s;
    lic_sync_t next_s;

    // First stage feeds only the second stage
    always_comb
    begin
        next_s = s;
        next_s.first = pin_raw;
        next_s.second = s.first;
        if (!rst_n)
        begin
            next_s = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        s <= next_s;
    end

    assign pin_sync = s.second;
endmodule
`default_nettype wire

// file: verif/lic_line_model.sv
// Line-side analog model: calibration engine and status pins
`timescale 1ns/1ps
`default_nettype none
module lic_line_model #(
    parameter int CAL_CYCLES = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Start from the block, scenario requests
    input wire logic cal_start,
    input wire logic rx_excess,
    input wire logic tone_on,
    // Status pins toward the block
    output logic rx_overload_pin,
    output logic billing_tone_pin,
    output logic cal_done_pin
);
    int cal_left;
    // Calibration takes CAL_CYCLES, then done stands two cycles
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cal_left <= 0;
        else if (cal_start)
            cal_left <= CAL_CYCLES + 2;
        else if (cal_left > 0)
            cal_left <= cal_left - 1;
    end
    assign cal_done_pin = (cal_left == 1) || (cal_left == 2);
    // Levels stand as long as the line condition lasts
    assign rx_overload_pin = rx_excess;
    assign billing_tone_pin = tone_on;
endmodule
`default_nettype wire

// file: verif/line_interface_intl_control2_tb.sv
// Self-checking bench for the control-two register block
`timescale 1ns/1ps
`default_nettype none
module line_interface_intl_control2_tb;
    import lic_pkg::*;
    localparam logic [7:0] A_C2 = {IDX_CTRL2, 2'b00};
    localparam logic [7:0] A_ST = {IDX_INT_STAT, 2'b00};
    localparam logic [7:0] A_MK = {IDX_INT_MASK, 2'b00};
    localparam logic [7:0] A_LS = {IDX_LINE_STAT, 2'b00};
    logic ref_clk, rst_n, wb_cyc, wb_stb, wb_we, off_hook, rx_excess, tone_on;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rdat;
    logic wb_ack_o, rx_pin, bill_pin, done_pin, cal_start, auto_en, limit_on, tdis, hred, hz;
    logic trk, irq;
    logic [4:0] loop_rd;
    logic [1:0] mode;
    int fail_count, comparisons, cal_cnt;
    // ----------------------------------------------------------------
    // Block, line model, clock and monitors
    // ----------------------------------------------------------------
    lic_control2 lic_control2_i (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .off_hook(off_hook),
        .loop_current_reading(loop_rd), .termination_mode_select(mode),
        .rx_overload_pin(rx_pin), .billing_tone_pin(bill_pin), .cal_done_pin(done_pin),
        .cal_start(cal_start), .auto_calibrate_enable(auto_en), .current_limit_active(limit_on),
        .termination_disable(tdis), .hook_current_reduce(hred), .termination_high_z(hz),
        .termination_tracking(trk), .irq(irq));
    lic_line_model lic_line_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .cal_start(cal_start),
        .rx_excess(rx_excess), .tone_on(tone_on), .rx_overload_pin(rx_pin),
        .billing_tone_pin(bill_pin), .cal_done_pin(done_pin));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Pulses are counted so a scenario can judge them after the fact
    always @(posedge ref_clk)
        if (!rst_n)
            cal_cnt <= 0;
        else if (cal_start === 1'b1)
            cal_cnt <= cal_cnt + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Classic single cycle; request held until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_dat <= dat;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20)
        begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic rd(input string what, input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        check(what, rdat, exp);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd("ctrl2 reset", A_C2, 32'h0);
        rd("mask reset", A_MK, 32'h0);
        check("auto cal enable", auto_en, 1'b1);
        check("tracking", trk, 1'b1);
        xfer(1'b1, 8'h10, 32'hff);
        rd("unmapped", 8'h10, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_manual_cal();
        int c0;
        c0 = cal_cnt;
        xfer(1'b1, A_C2, 32'h0);
        cyc(2);
        check("no cal on zero", cal_cnt, c0);
        xfer(1'b1, A_C2, 32'h40);
        cyc(2);
        check("manual cal", cal_cnt, c0 + 1);
        rd("calibrating", A_C2, 32'h40);
        cyc(20);
        rd("cal ended", A_C2, 32'h0);
        rd("cal event", A_ST, 32'h1);
        xfer(1'b1, A_ST, 32'hf);
        $display("manual calibration test done");
    endtask
    task automatic t_auto_cal();
        int c0;
        c0 = cal_cnt;
        xfer(1'b1, A_C2, 32'h20);
        check("auto cal off", auto_en, 1'b0);
        off_hook <= 1'b1;
        cyc(4);
        check("suppressed", cal_cnt, c0);
        off_hook <= 1'b0;
        xfer(1'b1, A_C2, 32'h0);
        off_hook <= 1'b1;
        cyc(4);
        check("auto cal", cal_cnt, c0 + 1);
        cyc(20);
        off_hook <= 1'b0;
        xfer(1'b1, A_ST, 32'hf);
        $display("auto calibration test done");
    endtask
    task automatic t_limit();
        for (int m = 0; m < 4; m++)
            for (int b = 0; b < 2; b++)
            begin
                mode <= 2'(m);
                xfer(1'b1, A_C2, 32'(b) << 4);
                check("current limit", limit_on, 1'(b == 1 && m == 3));
            end
        $display("current limit test done");
    endtask
    task automatic t_overload();
        xfer(1'b1, A_C2, 32'h20);
        loop_rd <= 5'h1f;
        off_hook <= 1'b1;
        cyc(3);
        check("no trip disabled", tdis, 1'b0);
        xfer(1'b1, A_C2, 32'h28);
        loop_rd <= 5'h1e;
        cyc(3);
        check("trip", tdis, 1'b1);
        check("hook reduce", hred, 1'b1);
        rd("line status", A_LS, 32'h5);
        rd("overload event", A_ST, 32'h2);
        xfer(1'b1, A_C2, 32'h20);
        cyc(3);
        check("trip reset", tdis, 1'b0);
        off_hook <= 1'b0;
        xfer(1'b1, A_ST, 32'hf);
        $display("overload test done");
    endtask
    task automatic t_billing();
        off_hook <= 1'b1;
        xfer(1'b1, A_C2, 32'h24);
        tone_on <= 1'b1;
        cyc(6);
        check("high z", hz, 1'b1);
        check("tracking stop", trk, 1'b0);
        rd("tone flag", A_C2, 32'h25);
        xfer(1'b1, A_C2, 32'h25);
        tone_on <= 1'b0;
        cyc(6);
        rd("tone sticky", A_C2, 32'h25);
        xfer(1'b1, A_C2, 32'h24);
        rd("tone cleared", A_C2, 32'h24);
        xfer(1'b1, A_C2, 32'h27);
        rd("no sw set", A_C2, 32'h24);
        off_hook <= 1'b0;
        cyc(3);
        check("high z end", hz, 1'b0);
        xfer(1'b1, A_C2, 32'h0);
        xfer(1'b1, A_ST, 32'hf);
        $display("billing test done");
    endtask
    task automatic t_rx_irq();
        xfer(1'b1, A_MK, 32'h4);
        rx_excess <= 1'b1;
        cyc(6);
        check("irq", irq, 1'b1);
        rd("rx flag", A_C2, 32'h2);
        rx_excess <= 1'b0;
        xfer(1'b1, A_MK, 32'h0);
        check("irq masked", irq, 1'b0);
        xfer(1'b1, A_MK, 32'h4);
        xfer(1'b1, A_ST, 32'h4);
        cyc(1);
        check("irq cleared", irq, 1'b0);
        rd("rx sticky", A_C2, 32'h2);
        xfer(1'b1, A_C2, 32'h0);
        rd("rx cleared", A_C2, 32'h0);
        $display("receive overload test done");
    endtask
    initial
    begin
        {rst_n, wb_cyc, wb_stb, wb_we, off_hook, rx_excess, tone_on} = '0;
        {wb_adr, wb_dat, wb_sel, loop_rd, mode} = '0;
        {fail_count, comparisons} = '0;
        cyc(10);
        rst_n <= 1'b1;
        t_reset();
        t_manual_cal();
        t_auto_cal();
        t_limit();
        t_overload();
        t_billing();
        t_rx_irq();
        give_verdict();
    end
    // Hang guard well beyond the scenario length
    initial
    begin
        cyc(20000);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
